// ===== rtl/ppc_pin_cell.sv
/*
 * One pin's control cell: analog priority, pull gating, slew and drive
 * qualification. Purely combinational.
 * Assumes the configuration comes from registers and peripheral override inputs in the parent.
 */
`timescale 1ns/10ps
module ppc_pin_cell
    import ppc_pkg::*;
(
    // Configuration
    input  wire ppc_pin_cfg_s cfg,
    // Pad controls
    output ppc_pad_ctl_s      ctl
);

    logic out_active;

    // Analog wins over any digital output
    assign out_active = (cfg.dir_out | cfg.periph_out_en) & ~cfg.analog_en;

    always_comb begin
        ctl.analog_on    = cfg.analog_en;
        ctl.pad_out      = cfg.periph_out_en ? cfg.periph_out : cfg.data_out;
        ctl.pad_oe_n     = ~out_active;
        ctl.pull_up_on   = cfg.pullup_en & ~out_active & ~cfg.analog_en
                           & ~cfg.pull_down_sel;
        ctl.pull_down_on = cfg.pullup_en & ~out_active & ~cfg.analog_en
                           & cfg.pull_down_sel;
        ctl.slew_on      = cfg.slew_en & out_active;
        ctl.drive_hi_on  = cfg.drive_hi & out_active;
    end

endmodule : ppc_pin_cell

// ===== rtl/ppc_pkg.sv
/*
 * Package for the port pin control block: register offsets, reset values,
 * field widths and the packed carriers shared by the block and its pin cell.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package ppc_pkg;

    localparam int          PPC_PINS       = 8;
    localparam int          PPC_AW         = 8;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0]  OFS_PORTA_DIR  = 8'h00;
    localparam logic [7:0]  OFS_PORTA_DATA = 8'h04;
    localparam logic [7:0]  OFS_PORTA_PUE  = 8'h08;
    localparam logic [7:0]  OFS_PORTA_SLEW = 8'h0C;
    localparam logic [7:0]  OFS_PORTA_ANA  = 8'h10;
    localparam logic [7:0]  OFS_PORTA_SEL  = 8'h14;
    localparam logic [7:0]  OFS_PORTA_POL  = 8'h18;
    localparam logic [7:0]  OFS_PORTA_PIN  = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h20;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h24;
    localparam logic [7:0]  OFS_PORTF_DIR  = 8'h28;
    localparam logic [7:0]  OFS_PORTF_DATA = 8'h2C;
    localparam logic [7:0]  OFS_PORTF_PUE  = 8'h30;
    localparam logic [7:0]  OFS_PORTF_SLEW = 8'h34;
    localparam logic [7:0]  OFS_PORTF_ANA  = 8'h38;
    localparam logic [7:0]  OFS_PORTF_DRV  = 8'h3C;
    localparam logic [7:0]  OFS_PORTF_PIN  = 8'h40;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  RST_SEL        = 8'h00;
    localparam logic [7:0]  RST_POL        = 8'h00;
    localparam logic [7:0]  RST_DRV        = 8'h00;
    localparam logic [7:0]  RST_SLEW       = 8'h00;

    // Per-pin configuration carried to the pin cell
    typedef struct packed {
        logic dir_out;
        logic data_out;
        logic periph_out_en;
        logic periph_out;
        logic pullup_en;
        logic slew_en;
        logic analog_en;
        logic pull_down_sel;
        logic drive_hi;
    } ppc_pin_cfg_s;

    // Per-pin pad controls
    typedef struct packed {
        logic pad_out;
        logic pad_oe_n;
        logic pull_up_on;
        logic pull_down_on;
        logic slew_on;
        logic drive_hi_on;
        logic analog_on;
    } ppc_pad_ctl_s;

endpackage : ppc_pkg

// ===== rtl/ppc_port_pin_control.sv
/*
 * Port pin control for ports A and F: APB register file, per-pin pad
 * control cells and the port A pin interrupt with sticky status and mask.
 * Assumes pins are synchronous to pclk and peripheral overrides come in
 * as plain inputs.
 */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module ppc_port_pin_control
    import ppc_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [PPC_AW-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Port A pins and peripheral overrides
    input  wire logic [PPC_PINS-1:0]  porta_pin_in,
    input  wire logic [PPC_PINS-1:0]  porta_periph_oe,
    input  wire logic [PPC_PINS-1:0]  porta_periph_out,
    output ppc_pad_ctl_s              porta_pad [PPC_PINS],
    // Port F pins and peripheral overrides
    input  wire logic [PPC_PINS-1:0]  portf_pin_in,
    input  wire logic [PPC_PINS-1:0]  portf_periph_oe,
    input  wire logic [PPC_PINS-1:0]  portf_periph_out,
    output ppc_pad_ctl_s              portf_pad [PPC_PINS],
    // Interrupt
    output logic                      irq
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] a_dir_q, a_data_q, a_pue_q, a_slew_q, a_ana_q;
    logic [7:0] a_sel_q, a_pol_q, irq_stat_q, irq_stat_d, irq_mask_q;
    logic [7:0] f_dir_q, f_data_q, f_pue_q, f_slew_q, f_ana_q, f_drv_q;
    logic [7:0] a_pin_q, a_act_q, a_act_d, a_event;
    logic       wr_en, rd_en, addr_ok;
    logic [7:0] wdat;

    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign wdat   = pwdata[7:0];
    assign pready = 1'b1;

    // ************************************************************
    // Address decode check
    // ************************************************************
    always_comb begin
        if (paddr == OFS_PORTA_DIR || paddr == OFS_PORTA_DATA || paddr == OFS_PORTA_PUE
            || paddr == OFS_PORTA_SLEW || paddr == OFS_PORTA_ANA) begin
            addr_ok = 1'b1;
        end else if (paddr == OFS_PORTA_SEL || paddr == OFS_PORTA_POL
            || paddr == OFS_PORTA_PIN || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK) begin
            addr_ok = 1'b1;
        end else if (paddr == OFS_PORTF_DIR || paddr == OFS_PORTF_DATA
            || paddr == OFS_PORTF_PUE || paddr == OFS_PORTF_SLEW) begin
            addr_ok = 1'b1;
        end else if (paddr == OFS_PORTF_ANA || paddr == OFS_PORTF_DRV
            || paddr == OFS_PORTF_PIN) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = psel & penable & ~addr_ok;

    // ************************************************************
    // Port A configuration
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_dir_q  <= RST_ZERO;
            a_data_q <= RST_ZERO;
            a_pue_q  <= RST_ZERO;
            a_slew_q <= RST_SLEW;
            a_ana_q  <= RST_ZERO;
        end else if (wr_en) begin
            if (paddr == OFS_PORTA_DIR) begin
                a_dir_q <= wdat;
            end else if (paddr == OFS_PORTA_DATA) begin
                a_data_q <= wdat;
            end else if (paddr == OFS_PORTA_PUE) begin
                a_pue_q <= wdat;
            end else if (paddr == OFS_PORTA_SLEW) begin
                a_slew_q <= wdat;
            end else if (paddr == OFS_PORTA_ANA) begin
                a_ana_q <= wdat;
            end
        end
    end

    // ************************************************************
    // Port A interrupt configuration
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_sel_q    <= RST_SEL;
            a_pol_q    <= RST_POL;
            irq_mask_q <= RST_ZERO;
        end else if (wr_en) begin
            if (paddr == OFS_PORTA_SEL) begin
                a_sel_q <= wdat;
            end else if (paddr == OFS_PORTA_POL) begin
                a_pol_q <= wdat;
            end else if (paddr == OFS_IRQ_MASK) begin
                irq_mask_q <= wdat;
            end
        end
    end

    // ************************************************************
    // Port F configuration
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_dir_q  <= RST_ZERO;
            f_data_q <= RST_ZERO;
            f_pue_q  <= RST_ZERO;
            f_slew_q <= RST_SLEW;
            f_ana_q  <= RST_ZERO;
            f_drv_q  <= RST_DRV;
        end else if (wr_en) begin
            if (paddr == OFS_PORTF_DIR) begin
                f_dir_q <= wdat;
            end else if (paddr == OFS_PORTF_DATA) begin
                f_data_q <= wdat;
            end else if (paddr == OFS_PORTF_PUE) begin
                f_pue_q <= wdat;
            end else if (paddr == OFS_PORTF_SLEW) begin
                f_slew_q <= wdat;
            end else if (paddr == OFS_PORTF_ANA) begin
                f_ana_q <= wdat;
            end else if (paddr == OFS_PORTF_DRV) begin
                f_drv_q <= wdat;
            end
        end
    end

    // ************************************************************
    // Port A interrupt detection
    // ************************************************************
    // Condition true when pin matches polarity: 0 low, 1 high
    assign a_act_d = ~(porta_pin_in ^ a_pol_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_pin_q <= RST_ZERO;
            a_act_q <= RST_ZERO;
        end else begin
            a_pin_q <= porta_pin_in;
            a_act_q <= a_act_d;
        end
    end

    // Edge into the active state on a selected pin
    assign a_event = a_sel_q & a_act_d & ~a_act_q;

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_en && paddr == OFS_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~wdat;
        end
        // Set beats a simultaneous clear
        irq_stat_d = irq_stat_d | a_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= RST_ZERO;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == OFS_PORTA_DIR) begin
                prdata <= {24'h00_0000, a_dir_q};
            end else if (paddr == OFS_PORTA_DATA) begin
                prdata <= {24'h00_0000, a_data_q};
            end else if (paddr == OFS_PORTA_PUE) begin
                prdata <= {24'h00_0000, a_pue_q};
            end else if (paddr == OFS_PORTA_SLEW) begin
                prdata <= {24'h00_0000, a_slew_q};
            end else if (paddr == OFS_PORTA_ANA) begin
                prdata <= {24'h00_0000, a_ana_q};
            end else if (paddr == OFS_PORTA_SEL) begin
                prdata <= {24'h00_0000, a_sel_q};
            end else if (paddr == OFS_PORTA_POL) begin
                prdata <= {24'h00_0000, a_pol_q};
            end else if (paddr == OFS_PORTA_PIN) begin
                prdata <= {24'h00_0000, a_pin_q};
            end else if (paddr == OFS_IRQ_STAT) begin
                prdata <= {24'h00_0000, irq_stat_q};
            end else if (paddr == OFS_IRQ_MASK) begin
                prdata <= {24'h00_0000, irq_mask_q};
            end else if (paddr == OFS_PORTF_DIR) begin
                prdata <= {24'h00_0000, f_dir_q};
            end else if (paddr == OFS_PORTF_DATA) begin
                prdata <= {24'h00_0000, f_data_q};
            end else if (paddr == OFS_PORTF_PUE) begin
                prdata <= {24'h00_0000, f_pue_q};
            end else if (paddr == OFS_PORTF_SLEW) begin
                prdata <= {24'h00_0000, f_slew_q};
            end else if (paddr == OFS_PORTF_ANA) begin
                prdata <= {24'h00_0000, f_ana_q};
            end else if (paddr == OFS_PORTF_DRV) begin
                prdata <= {24'h00_0000, f_drv_q};
            end else if (paddr == OFS_PORTF_PIN) begin
                prdata <= {24'h00_0000, portf_pin_in};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Pin cells
    // ************************************************************
    generate
        for (genvar i = 0; i < PPC_PINS; i++) begin : g_pin
            ppc_pin_cfg_s a_cfg, f_cfg;

            always_comb begin
                a_cfg.dir_out       = a_dir_q[i];
                a_cfg.data_out      = a_data_q[i];
                a_cfg.periph_out_en = porta_periph_oe[i];
                a_cfg.periph_out    = porta_periph_out[i];
                a_cfg.pullup_en     = a_pue_q[i];
                a_cfg.slew_en       = a_slew_q[i];
                a_cfg.analog_en     = a_ana_q[i];
                a_cfg.pull_down_sel = a_pol_q[i];
                a_cfg.drive_hi      = 1'b0;
                f_cfg.dir_out       = f_dir_q[i];
                f_cfg.data_out      = f_data_q[i];
                f_cfg.periph_out_en = portf_periph_oe[i];
                f_cfg.periph_out    = portf_periph_out[i];
                f_cfg.pullup_en     = f_pue_q[i];
                f_cfg.slew_en       = f_slew_q[i];
                f_cfg.analog_en     = f_ana_q[i];
                f_cfg.pull_down_sel = 1'b0;
                f_cfg.drive_hi      = f_drv_q[i];
            end

            ppc_pin_cell u_a (
                .cfg (a_cfg),
                .ctl (porta_pad[i])
            );

            ppc_pin_cell u_f (
                .cfg (f_cfg),
                .ctl (portf_pad[i])
            );
        end
    endgenerate

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_stat_clear;
        wr_en && paddr == OFS_IRQ_STAT;
    endsequence

    property p_event_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        (a_sel_q[0] && a_act_d[0] && !a_act_q[0]) |=> irq_stat_q[0];
    endproperty
    a_event_sets_flag: assert property (p_event_sets_flag) else $error("flag not set");

    property p_unsel_no_flag;
        @(posedge pclk) disable iff (!presetn)
        (!a_sel_q[0] && !irq_stat_q[0] && !(wr_en && paddr == OFS_IRQ_STAT))
        |=> !irq_stat_q[0];
    endproperty
    a_unsel_no_flag: assert property (p_unsel_no_flag) else $error("unselected pin flagged");

    property p_clear_flag;
        @(posedge pclk) disable iff (!presetn)
        (s_stat_clear and (wdat[1] && !a_event[1])) |=> !irq_stat_q[1];
    endproperty
    a_clear_flag: assert property (p_clear_flag) else $error("flag not cleared");

    property p_pol_low_edge;
        @(posedge pclk) disable iff (!presetn)
        (a_sel_q[2] && !a_pol_q[2] && $fell(porta_pin_in[2]) && $stable(a_pol_q[2]))
        |=> irq_stat_q[2];
    endproperty
    a_pol_low_edge: assert property (p_pol_low_edge) else $error("falling edge missed");

    property p_pol_high_edge;
        @(posedge pclk) disable iff (!presetn)
        (a_sel_q[2] && a_pol_q[2] && $rose(porta_pin_in[2]) && $stable(a_pol_q[2]))
        |=> irq_stat_q[2];
    endproperty
    a_pol_high_edge: assert property (p_pol_high_edge) else $error("rising edge missed");

    property p_analog_priority;
        @(posedge pclk) disable iff (!presetn)
        a_ana_q[0] |-> porta_pad[0].pad_oe_n && !porta_pad[0].pull_up_on;
    endproperty
    a_analog_priority: assert property (p_analog_priority) else $error("analog lost pin");

    property p_out_no_pull;
        @(posedge pclk) disable iff (!presetn)
        (a_dir_q[0] || porta_periph_oe[0])
        |-> !porta_pad[0].pull_up_on && !porta_pad[0].pull_down_on;
    endproperty
    a_out_no_pull: assert property (p_out_no_pull) else $error("pull on output");

    property p_in_no_drive;
        @(posedge pclk) disable iff (!presetn)
        portf_pad[2].pad_oe_n |-> !portf_pad[2].drive_hi_on && !portf_pad[2].slew_on;
    endproperty
    a_in_no_drive: assert property (p_in_no_drive) else $error("drive on input");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        (a_event[2] && irq_mask_q[2] && !(wr_en && paddr == OFS_IRQ_MASK)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised");

endmodule : ppc_port_pin_control

// ===== tb/ppc_pin_model.sv
/*
 * Board side of the port pins: resolves each pin level from the pad
 * controls, an optional external driver and the pull devices.
 * Assumes pad controls settle within a pclk cycle.
 */
`timescale 1ns/10ps
module ppc_pin_model
    import ppc_pkg::*;
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Pad controls and board drive
    input  wire ppc_pad_ctl_s        pad [PPC_PINS],
    input  wire logic [PPC_PINS-1:0] ext_en,
    input  wire logic [PPC_PINS-1:0] ext_val,
    // Pin levels
    output logic      [PPC_PINS-1:0] pin
);
    logic [PPC_PINS-1:0] float_q;

    // Floating pins wander every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            float_q <= 8'h00;
        end else begin
            float_q <= ~pin;
        end
    end

    always_comb begin
        for (int i = 0; i < PPC_PINS; i++) begin
            if (!pad[i].pad_oe_n && !pad[i].analog_on) begin
                pin[i] = pad[i].pad_out;
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pad[i].pull_up_on) begin
                pin[i] = 1'b1;
            end else if (pad[i].pull_down_on) begin
                pin[i] = 1'b0;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule : ppc_pin_model

// ===== tb/tb_ppc_port_pin_control.sv
/*
 * Testbench for the port pin control block: register table, pad control
 * and the port A pin interrupt. Assumes ppc_pkg and the pin model.
 */
`timescale 1ns/10ps
module tb_ppc_port_pin_control
    import ppc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } ppc_row_s;

    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0]   paddr, a_oe, a_en, a_val, pa_pin, pf_pin;
    logic [31:0]  pwdata, prdata, rd;
    ppc_pad_ctl_s pa_pad [PPC_PINS];
    ppc_pad_ctl_s pf_pad [PPC_PINS];
    ppc_row_s     rows [11];
    int           n_errors, tests_run;

    ppc_port_pin_control ppc_port_pin_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .porta_pin_in(pa_pin),
        .porta_periph_oe(a_oe), .porta_periph_out(8'h00), .porta_pad(pa_pad),
        .portf_pin_in(pf_pin), .portf_periph_oe(8'h00), .portf_periph_out(8'h00),
        .portf_pad(pf_pad), .irq(irq));
    ppc_pin_model pin_model_a (.pclk(pclk), .presetn(presetn), .pad(pa_pad),
        .ext_en(a_en), .ext_val(a_val), .pin(pa_pin));
    ppc_pin_model pin_model_f (.pclk(pclk), .presetn(presetn), .pad(pf_pad),
        .ext_en(8'h00), .ext_val(8'h00), .pin(pf_pin));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic pad_chk(input ppc_pad_ctl_s p, input logic [5:0] e, input logic [5:0] m);
        chk({26'h0, p[5:0] & m}, {26'h0, e & m});
    endtask : pad_chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(pready === 1'b1) && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop;
        end else begin
            #1;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, a_oe} = '0;
        a_en = 8'h0C;
        a_val = 8'h0C;
        n_errors = 0;
        tests_run = 0;
        rows = '{'{OFS_PORTA_DIR, 32'hFFFFFF5A, 32'h5A}, '{OFS_PORTA_PUE, 32'hFFFFFFA5, 32'hA5},
                 '{OFS_PORTA_SLEW, 32'hFFFFFF3C, 32'h3C}, '{OFS_PORTA_ANA, 32'hFFFFFFC3, 32'hC3},
                 '{OFS_PORTA_SEL, 32'hFFFFFF81, 32'h81}, '{OFS_PORTA_POL, 32'hFFFFFF7E, 32'h7E},
                 '{OFS_IRQ_MASK, 32'hFFFFFF18, 32'h18}, '{OFS_PORTF_DRV, 32'hFFFFFFE7, 32'hE7},
                 '{OFS_PORTF_SLEW, 32'hFFFFFF69, 32'h69}, '{OFS_PORTF_PUE, 32'hFFFFFF96, 32'h96},
                 '{8'h44, 32'hFFFFFFFF, 32'h0}};
        do_reset;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        chk({31'h0, er}, 32'h1);
        do_reset;
        chk({31'h0, irq}, 32'h0);
        foreach (rows[i]) rdchk(rows[i].a, 32'h0);
        wr(OFS_PORTA_PUE, 8'h01);
        pad_chk(pa_pad[0], 6'b110000, 6'h3F);
        rdchk(OFS_PORTA_PIN, {24'h0, pa_pin[7:1], 1'b1});
        wr(OFS_PORTA_POL, 8'h01);
        pad_chk(pa_pad[0], 6'b101000, 6'h3F);
        wr(OFS_PORTA_POL, 8'h00);
        wr(OFS_PORTA_SLEW, 8'h01);
        pad_chk(pa_pad[0], 6'b110000, 6'h3F);
        wr(OFS_PORTA_DATA, 8'h01);
        wr(OFS_PORTA_DIR, 8'h01);
        pad_chk(pa_pad[0], 6'b000100, 6'h3F);
        chk({31'h0, pa_pin[0]}, 32'h1);
        wr(OFS_PORTA_DIR, 8'h00);
        @(posedge pclk);
        a_oe[0] <= 1'b1;
        #1;
        pad_chk(pa_pad[0], 6'b000100, 6'b111000);
        wr(OFS_PORTA_ANA, 8'h01);
        pad_chk(pa_pad[0], 6'b100001, 6'b111001);
        wr(OFS_PORTF_DRV, 8'h01);
        pad_chk(pf_pad[0], 6'b000000, 6'b000010);
        wr(OFS_PORTF_DIR, 8'h01);
        pad_chk(pf_pad[0], 6'b000010, 6'b000010);
        wr(OFS_PORTA_SEL, 8'h04);
        wr(OFS_IRQ_MASK, 8'h04);
        wr(OFS_IRQ_STAT, 8'hFF);
        rdchk(OFS_IRQ_STAT, 32'h0);
        @(posedge pclk);
        a_val[2] <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(OFS_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STAT, 8'h04);
        rdchk(OFS_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_PORTA_POL, 8'h04);
        rdchk(OFS_IRQ_STAT, 32'h0);
        @(posedge pclk);
        a_val[2] <= 1'b1;
        a_val[3] <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(OFS_IRQ_STAT, 32'h4);
        wr(OFS_IRQ_MASK, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 8'h04);
        chk({31'h0, irq}, 32'h1);
        report_and_stop;
    end
endmodule : tb_ppc_port_pin_control
